// ### hdl/clhi_defs.vh
`ifndef CLHI_DEFS_VH
`define CLHI_DEFS_VH

// instruction opcode positions (highest set bit selects the instruction)
`define CLHI_OP_SET_CHAR   7
`define CLHI_OP_SET_GLYPH  6
`define CLHI_OP_FUNC_SET   5
`define CLHI_OP_SHIFT      4
`define CLHI_OP_ENTRY      2
// function-set, shift and entry-mode field positions
`define CLHI_FS_WIDTH      4
`define CLHI_FS_LINES      3
`define CLHI_FS_FONT       2
`define CLHI_SH_DISPLAY    3
`define CLHI_SH_RIGHT      2
`define CLHI_EM_INC        1
// character ram address ranges
`define CLHI_ONE_LINE_LAST 7'h4f
`define CLHI_LINE1_LAST    7'h27
`define CLHI_LINE2_FIRST   7'h40
`define CLHI_LINE2_LAST    7'h67
// duty factor denominators
`define CLHI_DUTY_1L_5X8   5'h08
`define CLHI_DUTY_1L_5X11  5'h0b
`define CLHI_DUTY_2L       5'h10
// interface strap codes {hi, lo}
`define CLHI_IF_PARALLEL   2'h0
`define CLHI_IF_TWO_WIRE   2'h1
`define CLHI_IF_SPI        2'h2
// reset values
`define CLHI_RST_WIDTH     1'b1
`define CLHI_RST_INC       1'b1
// execution time of an instruction in ns, and as clock cycles at 100 ns
`define CLHI_EXEC_NS       18500
`define CLHI_CLK_NS        100
`define CLHI_EXEC_CYC      ((`CLHI_EXEC_NS + `CLHI_CLK_NS - 1) / `CLHI_CLK_NS)

`endif

// ### hdl/clhi_sync2.v
`timescale 1ns/10ps
module clhi_sync2 #(
  parameter W = 1
) (
  input  wire         mclk,
  input  wire         srst,
  input  wire [W-1:0] asyncIn,
  output reg  [W-1:0] syncOut
);
  reg [W-1:0] meta_q;

  always @(posedge mclk) begin
    if (srst) begin
      meta_q  <= {W{1'b0}};
      syncOut <= {W{1'b0}};
    end else begin
      meta_q  <= asyncIn;
      syncOut <= meta_q;
    end
  end
endmodule

// ### hdl/clhi_buf2.v
`timescale 1ns/10ps
// two-entry buffer; ready on the fill side drops only when both slots hold words
module clhi_buf2 #(
  parameter W = 9
) (
  input  wire         mclk,
  input  wire         srst,
  input  wire         inValid,
  output wire         inReady,
  input  wire [W-1:0] inData,
  output wire         outValid,
  input  wire         outReady,
  output wire [W-1:0] outData
);
  reg [W-1:0] mem_q [0:1];
  reg         wrPtr_q;
  reg         rdPtr_q;
  reg [1:0]   count_q;
  wire        push;
  wire        pop;

  assign inReady  = (count_q != 2'h2);
  assign outValid = (count_q != 2'h0);
  assign outData  = mem_q[rdPtr_q];
  assign push     = inValid & inReady;
  assign pop      = outValid & outReady;

  always @(posedge mclk) begin
    if (srst) begin
      wrPtr_q <= 1'b0;
      rdPtr_q <= 1'b0;
      count_q <= 2'h0;
    end else begin
      if (push) begin
        mem_q[wrPtr_q] <= inData;
        wrPtr_q        <= ~wrPtr_q;
      end
      if (pop) begin
        rdPtr_q <= ~rdPtr_q;
      end
      if (push & ~pop) begin
        count_q <= count_q + 2'h1;
      end else if (pop & ~push) begin
        count_q <= count_q - 2'h1;
      end
    end
  end
endmodule

// ### hdl/clhi_core.v
`timescale 1ns/10ps
`include "clhi_defs.vh"
// Notes on behaviour
// - bus width bit set gives 8-bit transfers, cleared gives two 4-bit transfers; serial modes force 8-bit.
// - line bit 0 gives one line, duty 1/8 or 1/11; 1 gives two lines, 1/16.
// - font bit picks 5x8 or 5x11 cell, in one-line mode only.
// - glyph address set loads 6-bit pointer and selects glyph ram.
// - char address set loads 7-bit pointer and selects char ram.
// - one-line char ram addresses run 00h through 4fh contiguously.
// - two-line char ram uses 00h-27h then 40h-67h.
// - parallel status read returns busy flag on bit 7 and pointer below.
// - data write stores byte in selected ram, then steps pointer by one.
// - parallel data read returns byte from selected ram; none over serial.
// - without prior address set, first read byte is invalid.
// - cursor shift prefetches char ram data like a char address set, unless glyph ram is selected.
// - each data read steps pointer by one per entry direction.
// - read right after a write returns previously fetched data.
// - 4-bit mode uses upper four lines, high nibble first then low.
// - in 4-bit mode busy rises only after the second nibble.
// - straps pick parallel or 4-line spi; the two-wire code leaves both front ends off.
// - parallel uses strobe, select, read/write and eight or upper four lines.
// - spi uses chip select on line 5, data on 7, clock on 6, plus select.
// - entry direction set increments pointer, cleared decrements.
module clhi_core #(
  parameter EXEC_CYC = `CLHI_EXEC_CYC
) (
  input  wire       mclk,
  input  wire       srst,
  input  wire       ifaceStrapHi,
  input  wire       ifaceStrapLo,
  input  wire       enStrobe,
  input  wire       cmdDataSel,
  input  wire       readNotWrite,
  input  wire [7:0] dbIn,
  output reg  [7:0] dbOut,
  output wire       dbOe_n,
  output wire       busWidthSel,
  output wire       twoLineMode,
  output wire       bigFont,
  output reg  [4:0] dutyDenom,
  output wire       glyphSelected,
  output wire       opInProgressFlag,
  output wire [6:0] ramPointer,
  output wire       stallSeen
);
  localparam ST_IDLE  = 2'h0;
  localparam ST_EXEC  = 2'h1;
  localparam ST_FETCH = 2'h2;

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  wire [12:0] pinSync;
  clhi_sync2 #(.W(13)) uSync (
    .mclk    (mclk),
    .srst    (srst),
    .asyncIn ({enStrobe, cmdDataSel, readNotWrite, ifaceStrapHi, ifaceStrapLo, dbIn}),
    .syncOut (pinSync)
  );
  wire       strobeS = pinSync[12];
  wire       selS    = pinSync[11];
  wire       rdS     = pinSync[10];
  wire [7:0] dbS     = pinSync[7:0];

  ////////////////////////////////////////////////////////////////////////////
  // mode state
  reg        width_q;
  reg        lines_q;
  reg        font_q;
  reg        inc_q;
  reg        glyph_q;
  reg  [6:0] ptr_q;
  reg  [7:0] hold_q;     // data_hold_reg: prefetched read byte
  reg  [1:0] state_q;
  reg  [15:0] execCnt_q;
  reg        nibHalf_q;
  reg  [3:0] hiNib_q;
  reg        strobeOld_q;
  reg        sckOld_q;
  reg  [2:0] bitCnt_q;
  reg  [7:0] shift_q;
  reg  [1:0] mode_q;
  reg        fetchPending_q;

  reg  [7:0] glyphRam [0:63];
  reg  [7:0] charRam  [0:127];

  assign busWidthSel      = width_q;
  assign twoLineMode      = lines_q;
  assign bigFont          = font_q & ~lines_q;
  assign glyphSelected    = glyph_q;
  assign opInProgressFlag = (state_q != ST_IDLE);
  assign ramPointer       = ptr_q;

  always @* begin
    if (lines_q)
      dutyDenom = `CLHI_DUTY_2L;
    else if (font_q)
      dutyDenom = `CLHI_DUTY_1L_5X11;
    else
      dutyDenom = `CLHI_DUTY_1L_5X8;
  end

  ////////////////////////////////////////////////////////////////////////////
  // strap capture after reset release; the synchroniser is cleared by reset,
  // so wait two edges until it shows the real strap levels
  wire       strapHi = pinSync[9];
  wire       strapLo = pinSync[8];
  reg        strapDone_q;
  reg  [1:0] strapCnt_q;
  always @(posedge mclk) begin
    if (srst) begin
      mode_q      <= `CLHI_IF_PARALLEL;
      strapDone_q <= 1'b0;
      strapCnt_q  <= 2'h0;
    end else if (strapCnt_q != 2'h2) begin
      strapCnt_q  <= strapCnt_q + 2'h1;
    end else if (!strapDone_q) begin
      mode_q      <= {strapHi, strapLo};
      strapDone_q <= 1'b1;
    end
  end
  wire isPar = (mode_q == `CLHI_IF_PARALLEL);
  wire isSpi = (mode_q == `CLHI_IF_SPI);

  ////////////////////////////////////////////////////////////////////////////
  // parallel front end
  wire strobeFall = strobeOld_q & ~strobeS;
  wire [3:0] nib  = dbS[7:4];
  wire parWrEv    = isPar & strobeFall & ~rdS;
  wire parRdEv    = isPar & strobeFall & rdS;
  // a byte completes on the second nibble in 4-bit mode
  wire byteDone   = width_q | nibHalf_q;
  wire [7:0] parByte = width_q ? dbS : {hiNib_q, nib};

  // spi front end: clock on line 6, data on 7, select on 5
  wire csN    = dbS[5];
  wire sck    = dbS[6];
  wire sdi    = dbS[7];
  wire sckRise = ~sckOld_q & sck & ~csN;
  wire spiDone = isSpi & sckRise & (bitCnt_q == 3'h7);
  wire [7:0] spiByte = {shift_q[6:0], sdi};

  wire       wrReady;
  wire       bufValid;
  wire [8:0] bufData;
  wire       inPush = (parWrEv & byteDone) | spiDone;
  wire [8:0] inWord = isSpi ? {selS, spiByte} : {selS, parByte};
  clhi_buf2 #(.W(9)) uBuf (
    .mclk     (mclk),
    .srst     (srst),
    .inValid  (inPush),
    .inReady  (wrReady),
    .inData   (inWord),
    .outValid (bufValid),
    .outReady (state_q == ST_IDLE),
    .outData  (bufData)
  );
  assign stallSeen = inPush & ~wrReady;

  always @(posedge mclk) begin
    if (srst) begin
      strobeOld_q <= 1'b0;
      sckOld_q    <= 1'b1;
      nibHalf_q   <= 1'b0;
      hiNib_q     <= 4'h0;
      bitCnt_q    <= 3'h0;
      shift_q     <= 8'h00;
    end else begin
      strobeOld_q <= strobeS;
      sckOld_q    <= sck;
      if (isPar & strobeFall & ~width_q) begin
        nibHalf_q <= ~nibHalf_q;
        if (!nibHalf_q)
          hiNib_q <= nib;
      end
      if (csN) begin
        bitCnt_q <= 3'h0;
      end else if (sckRise) begin
        bitCnt_q <= bitCnt_q + 3'h1;
        shift_q  <= spiByte;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pointer stepping with two-line wrap
  function [6:0] stepPtr;
    input [6:0] p;
    input       up;
    input       glyph;
    input       two;
    begin
      if (glyph)
        stepPtr = {1'b0, up ? p[5:0] + 6'h01 : p[5:0] - 6'h01};
      else if (!two)
        stepPtr = up ? ((p >= `CLHI_ONE_LINE_LAST) ? 7'h00 : p + 7'h01)
                     : ((p == 7'h00) ? `CLHI_ONE_LINE_LAST : p - 7'h01);
      else if (up)
        stepPtr = (p == `CLHI_LINE1_LAST) ? `CLHI_LINE2_FIRST :
                  (p >= `CLHI_LINE2_LAST) ? 7'h00 : p + 7'h01;
      else
        stepPtr = (p == `CLHI_LINE2_FIRST) ? `CLHI_LINE1_LAST :
                  (p == 7'h00) ? `CLHI_LINE2_LAST : p - 7'h01;
    end
  endfunction

  wire [7:0] cmd   = bufData[7:0];
  wire       isDat = bufData[8];
  wire [7:0] ramQ  = glyph_q ? glyphRam[ptr_q[5:0]] : charRam[ptr_q];

  ////////////////////////////////////////////////////////////////////////////
  // instruction execution
  always @(posedge mclk) begin
    if (srst) begin
      width_q        <= `CLHI_RST_WIDTH;
      lines_q        <= 1'b0;
      font_q         <= 1'b0;
      inc_q          <= `CLHI_RST_INC;
      glyph_q        <= 1'b0;
      ptr_q          <= 7'h00;
      hold_q         <= 8'h00;
      state_q        <= ST_IDLE;
      execCnt_q      <= 16'h0000;
      fetchPending_q <= 1'b0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (parRdEv & selS & byteDone) begin
            ptr_q <= stepPtr(ptr_q, inc_q, glyph_q, lines_q);
            // new byte lands in the hold register for the next read
            state_q <= ST_FETCH;
          end else if (bufValid) begin
            state_q   <= ST_EXEC;
            execCnt_q <= EXEC_CYC[15:0];
            if (isDat) begin
              if (glyph_q)
                glyphRam[ptr_q[5:0]] <= cmd;
              else
                charRam[ptr_q] <= cmd;
              // hold is left alone so an immediate read sees the old byte
              ptr_q <= stepPtr(ptr_q, inc_q, glyph_q, lines_q);
            end else if (cmd[`CLHI_OP_SET_CHAR]) begin
              ptr_q          <= cmd[6:0];
              glyph_q        <= 1'b0;
              fetchPending_q <= 1'b1;
            end else if (cmd[`CLHI_OP_SET_GLYPH]) begin
              ptr_q          <= {1'b0, cmd[5:0]};
              glyph_q        <= 1'b1;
              fetchPending_q <= 1'b1;
            end else if (cmd[`CLHI_OP_FUNC_SET]) begin
              width_q <= isPar ? cmd[`CLHI_FS_WIDTH] : 1'b1;
              lines_q <= cmd[`CLHI_FS_LINES];
              font_q  <= cmd[`CLHI_FS_FONT];
            end else if (cmd[`CLHI_OP_SHIFT]) begin
              if (!cmd[`CLHI_SH_DISPLAY]) begin
                ptr_q          <= stepPtr(ptr_q, cmd[`CLHI_SH_RIGHT], glyph_q, lines_q);
                fetchPending_q <= ~glyph_q;
              end
            end else if (cmd[`CLHI_OP_ENTRY]) begin
              inc_q <= cmd[`CLHI_EM_INC];
            end
          end
        end
        ST_EXEC: begin
          if (execCnt_q > 16'h0001) begin
            execCnt_q <= execCnt_q - 16'h0001;
          end else if (fetchPending_q) begin
            state_q <= ST_FETCH;
          end else begin
            state_q <= ST_IDLE;
          end
        end
        ST_FETCH: begin
          hold_q         <= ramQ;
          fetchPending_q <= 1'b0;
          state_q        <= ST_IDLE;
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // parallel read data, both nibbles served from one snapshot
  reg [7:0] rdSnap_q;
  wire      readOn = isPar & strobeS & rdS;
  always @(posedge mclk) begin
    if (srst) begin
      rdSnap_q <= 8'h00;
      dbOut    <= 8'h00;
    end else begin
      if (~strobeOld_q & strobeS & rdS & ~nibHalf_q)
        rdSnap_q <= selS ? hold_q : {opInProgressFlag, ptr_q};
      if (width_q)
        dbOut <= selS ? hold_q : {opInProgressFlag, ptr_q};
      else
        dbOut <= nibHalf_q ? {rdSnap_q[3:0], 4'h0} : rdSnap_q;
    end
  end
  assign dbOe_n = ~readOn;
endmodule

// ### sim/clhi_core_asserts.sv
`timescale 1ns/10ps
module clhi_core_asserts #(
  parameter EXEC_CYC = 185
) (
  input wire       mclk,
  input wire       srst,
  input wire       ifaceStrapHi,
  input wire       readNotWrite,
  input wire       dbOe_n,
  input wire       busWidthSel,
  input wire       twoLineMode,
  input wire       bigFont,
  input wire [4:0] dutyDenom,
  input wire       glyphSelected,
  input wire       opInProgressFlag,
  input wire [6:0] ramPointer,
  input wire       stallSeen
);
  reg [11:0] busyRun_q;
  default clocking @(posedge mclk);
  endclocking
  default disable iff (srst);
  // a full buffer holds two jobs behind the one executing, but the core goes idle for one cycle between them
  always @(posedge mclk) begin
    if (srst || !opInProgressFlag)
      busyRun_q <= 12'h000;
    else
      busyRun_q <= busyRun_q + 12'h001;
  end
  ////////////////////
  a_duty_two_line: assert property (
    twoLineMode && $stable(twoLineMode) |-> dutyDenom == 5'h10) else $error("duty");
  a_duty_one_line: assert property (
    !twoLineMode && $stable({twoLineMode, bigFont})
    |-> dutyDenom == (bigFont ? 5'h0b : 5'h08)) else $error("duty");
  a_font_one_line: assert property (
    twoLineMode |-> !bigFont) else $error("font");
  a_drive_on_read: assert property (
    !dbOe_n |-> $past(readNotWrite, 2)) else $error("drive");
  a_serial_no_read: assert property (
    ifaceStrapHi |-> dbOe_n) else $error("serial read");
  a_serial_width: assert property (
    ifaceStrapHi |-> busWidthSel) else $error("width");
  a_glyph_six_bit: assert property (
    glyphSelected && $stable(glyphSelected) |-> !ramPointer[6]) else $error("glyph");
  a_one_line_map: assert property (
    !twoLineMode && !glyphSelected |-> ramPointer <= 7'h4f) else $error("map");
  a_two_line_map: assert property (
    twoLineMode && !glyphSelected |-> ramPointer <= 7'h27
    || (ramPointer >= 7'h40 && ramPointer <= 7'h67)) else $error("map");
  a_busy_min: assert property (
    $rose(opInProgressFlag) |-> opInProgressFlag[*4]) else $error("busy");
  a_busy_bounded: assert property (
    busyRun_q <= 3 * (EXEC_CYC + 2)) else $error("busy");
  cover property (twoLineMode && dutyDenom == 5'h10);
  cover property (stallSeen);
  cover property (!dbOe_n && !busWidthSel);
endmodule
bind clhi_core clhi_core_asserts #(.EXEC_CYC(EXEC_CYC)) i_clhi_core_asserts (
  .mclk(mclk), .srst(srst), .ifaceStrapHi(ifaceStrapHi), .readNotWrite(readNotWrite),
  .dbOe_n(dbOe_n), .busWidthSel(busWidthSel), .twoLineMode(twoLineMode),
  .bigFont(bigFont), .dutyDenom(dutyDenom), .glyphSelected(glyphSelected),
  .opInProgressFlag(opInProgressFlag), .ramPointer(ramPointer), .stallSeen(stallSeen));

// ### sim/clhi_host_model.sv
`timescale 1ns/10ps
module clhi_host_model (
  input  wire       mclk,
  input  wire [7:0] dbOut,
  input  wire       dbOe_n,
  output reg        enStrobe,
  output reg        cmdDataSel,
  output reg        readNotWrite,
  output wire [7:0] dbIn,
  output reg        rdValid,
  output reg  [7:0] rdByte
);
  reg [7:0] drv;
  // the core owns the wire while its enable is low
  assign dbIn = dbOe_n ? drv : dbOut;
  initial begin
    enStrobe = 1'b0;
    cmdDataSel = 1'b0;
    readNotWrite = 1'b0;
    rdValid = 1'b0;
    rdByte = 8'h00;
    drv = 8'he0;
  end
  ////////////////////
  task xfer(input rs, input rd, input wide, input [7:0] b);
    integer k;
    begin
      for (k = 0; k < (wide ? 1 : 2); k = k + 1) begin
        @(negedge mclk);
        cmdDataSel = rs;
        readNotWrite = rd;
        if (!rd)
          drv = wide ? b : (k == 0 ? {b[7:4], ~b[3:0]} : {b[3:0], ~b[7:4]});
        enStrobe = 1'b1;
        repeat (4) @(negedge mclk);
        if (rd)
          rdByte = wide ? dbOut : {rdByte[3:0], dbOut[7:4]};
        enStrobe = 1'b0;
        repeat (4) @(negedge mclk);
        drv = ~drv;
      end
      rdValid = rd;
      @(negedge mclk);
      rdValid = 1'b0;
    end
  endtask
  ////////////////////
  task spi(input rs, input [7:0] b);
    integer k;
    begin
      @(negedge mclk);
      cmdDataSel = rs;
      drv = 8'he0;
      repeat (4) @(negedge mclk);
      drv[5] = 1'b0;
      for (k = 7; k >= 0; k = k - 1) begin
        repeat (4) @(negedge mclk);
        drv[6] = 1'b0;
        drv[7] = b[k];
        repeat (4) @(negedge mclk);
        drv[6] = 1'b1;
      end
      repeat (4) @(negedge mclk);
      drv[5] = 1'b1;
      drv[7] = ~drv[7];
    end
  endtask
endmodule

// ### sim/tb.sv
`timescale 1ns/10ps
module tb;
  reg         mclk = 1'b0;
  reg         srst = 1'b1;
  reg         strapHi = 1'b0;
  wire [7:0]  dbIn;
  wire [7:0]  dbOut;
  wire [7:0]  rdByte;
  wire [4:0]  duty;
  wire [6:0]  ptr;
  wire        stb, rs, rnw, oe_n, width, two, big, glyph, busy, stall, rdValid;
  reg  [7:0]  expQ [$];
  reg  [31:0] rng = 32'h03f150e3;
  reg  [7:0]  a, b;
  reg         wide = 1'b1;
  reg         stalled = 1'b0;
  integer     n_errors = 0;
  integer     checks_done = 0;
  integer     i;
  always #50 mclk = ~mclk;
  clhi_core #(.EXEC_CYC(40)) i_clhi_core (
    .mclk(mclk), .srst(srst), .ifaceStrapHi(strapHi), .ifaceStrapLo(1'b0),
    .enStrobe(stb), .cmdDataSel(rs), .readNotWrite(rnw), .dbIn(dbIn), .dbOut(dbOut),
    .dbOe_n(oe_n), .busWidthSel(width), .twoLineMode(two), .bigFont(big),
    .dutyDenom(duty), .glyphSelected(glyph), .opInProgressFlag(busy),
    .ramPointer(ptr), .stallSeen(stall));
  clhi_host_model i_clhi_host_model (
    .mclk(mclk), .dbOut(dbOut), .dbOe_n(oe_n), .enStrobe(stb), .cmdDataSel(rs),
    .readNotWrite(rnw), .dbIn(dbIn), .rdValid(rdValid), .rdByte(rdByte));
  ////////////////////
  function [7:0] xs(input [31:0] s);
    begin
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      rng = s ^ (s << 5);
      xs = rng[7:0];
    end
  endfunction
  task check(input [7:0] seen, input [7:0] exp);
    begin
      checks_done = checks_done + 1;
      if (seen !== exp) begin
        n_errors = n_errors + 1;
        $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
    end
  endtask
  task close_out;
    begin
      $display("errors=%0d checks=%0d", n_errors, checks_done);
      if (n_errors == 0 && checks_done > 0)
        $display("ALL TESTS PASSED");
      else
        $display("TESTS FAILED");
      $finish;
    end
  endtask
  // five quiet cycles, so a refill from the buffer is not mistaken for idle
  task idle;
    integer k, q;
    begin
      q = 0;
      for (k = 0; k < 1000 && q < 5; k = k + 1) begin
        @(negedge mclk);
        q = busy ? 0 : q + 1;
      end
    end
  endtask
  task op(input rsel, input rd, input [7:0] v);
    begin
      i_clhi_host_model.xfer(rsel, rd, wide, v);
      idle;
    end
  endtask
  task rd(input rsel, input [7:0] e);
    begin
      expQ.push_back(e);
      op(rsel, 1'b1, 8'h00);
    end
  endtask
  ////////////////////
  always @(posedge mclk) begin
    if (rdValid)
      check(rdByte, expQ.pop_front());
    if (stall === 1'b1)
      stalled <= 1'b1;
  end
  initial begin
    #2000000;
    n_errors = n_errors + 1;
    close_out;
  end
  initial begin
    repeat (3) @(negedge mclk);
    srst = 1'b0;
    repeat (3) @(negedge mclk);
    check({width, busy, oe_n, ptr[4:0]}, 8'ha0);
    for (i = 0; i < 4; i = i + 1) begin
      op(0, 0, {4'h3, i[1:0], 2'b00});
      check({two, big, 1'b0, duty}, {i[1], i == 1, 1'b0,
            i[1] ? 5'h10 : (i[0] ? 5'h0b : 5'h08)});
    end
    a = xs(rng);
    op(0, 0, 8'ha7);
    op(1, 0, a);
    rd(0, 8'h40);
    op(0, 0, 8'ha7);
    rd(1, a);
    op(0, 0, 8'h30);
    op(0, 0, 8'ha7);
    b = xs(rng);
    op(1, 0, b);
    rd(0, 8'h28);
    op(0, 0, 8'h04);
    a = xs(rng);
    op(1, 0, a);
    rd(0, 8'h27);
    op(0, 0, 8'ha8);
    rd(1, a);
    rd(1, b);
    op(0, 0, 8'h06);
    op(0, 0, 8'ha8);
    op(0, 0, 8'h10);
    rd(1, b);
    op(0, 0, 8'h7e);
    check({glyph, ptr}, 8'hbe);
    a = xs(rng);
    op(1, 0, a);
    op(0, 0, 8'h7e);
    rd(1, a);
    op(0, 0, 8'h20);
    check({7'h00, width}, 8'h00);
    wide = 1'b0;
    op(0, 0, 8'h85);
    b = xs(rng);
    op(1, 0, b);
    op(0, 0, 8'h85);
    rd(1, b);
    rd(0, 8'h06);
    op(0, 0, 8'h30);
    wide = 1'b1;
    op(0, 0, 8'h80);
    for (i = 0; i < 4; i = i + 1)
      i_clhi_host_model.xfer(1, 0, 1, i[7:0]);
    idle;
    check({7'h00, stalled}, 8'h01);
    rd(0, 8'h03);
    srst = 1'b1;
    strapHi = 1'b1;
    repeat (3) @(negedge mclk);
    srst = 1'b0;
    repeat (3) @(negedge mclk);
    i_clhi_host_model.spi(0, 8'h20);
    idle;
    i_clhi_host_model.spi(0, 8'h95);
    idle;
    i_clhi_host_model.spi(1, xs(rng));
    idle;
    check({width, ptr}, 8'h96);
    close_out;
  end
endmodule
